/* core/isdp_buf2.v */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "isdp_regs.vh"
module isdp_buf2 (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // filling side
   input wire in_valid,
   output reg in_ready_r,
   input wire [`ISDP_TX_BUF_W-1:0] in_data,
   // draining side
   output reg out_valid_r,
   input wire out_ready,
   output reg [`ISDP_TX_BUF_W-1:0] out_data_r
);
   reg [`ISDP_TX_BUF_W-1:0] spare_r;
   reg spare_v_r;
   wire push;
   wire pop;

   assign push = in_valid & in_ready_r;
   assign pop = out_valid_r & out_ready;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid_r <= 1'b0;
         spare_v_r <= 1'b0;
         in_ready_r <= 1'b1;
         out_data_r <= {`ISDP_TX_BUF_W{1'b0}};
         spare_r <= {`ISDP_TX_BUF_W{1'b0}};
      end else begin
         if (pop) begin
            if (spare_v_r) begin
               out_data_r <= spare_r;
               out_valid_r <= 1'b1;
               spare_v_r <= 1'b0;
               in_ready_r <= 1'b1;
            end else begin
               out_data_r <= in_data;
               out_valid_r <= push;
            end
         end else if (push) begin
            if (!out_valid_r) begin
               out_data_r <= in_data;
               out_valid_r <= 1'b1;
            end else begin
               spare_r <= in_data;
               spare_v_r <= 1'b1;
               in_ready_r <= 1'b0;
            end
         end
      end
   end
endmodule // isdp_buf2

/* core/isdp_regs.vh */
// register offsets, field positions and build constants of the dma port block
`ifndef ISDP_REGS_VH
`define ISDP_REGS_VH

// register byte offsets
`define ISDP_ADDR_W 12
`define ISDP_OFF_RX_PORT 12'h1c0
`define ISDP_OFF_RX_RESTART 12'h1c4
`define ISDP_OFF_TX_PORT 12'h1c8
`define ISDP_OFF_TX_RESTART 12'h1cc
`define ISDP_OFF_PARAM_ONE 12'h1f4
`define ISDP_OFF_VERSION 12'h1f8
`define ISDP_OFF_RX_SIZES 12'h1f0

// restart bit position
`define ISDP_RESTART_BIT 0

// word size codes
`define ISDP_WS_12 3'h0
`define ISDP_WS_16 3'h1
`define ISDP_WS_20 3'h2
`define ISDP_WS_24 3'h3
`define ISDP_WS_32 3'h4

// build values reported by the parameter and receive size registers
`define ISDP_RX_WS0 `ISDP_WS_16
`define ISDP_RX_WS1 `ISDP_WS_16
`define ISDP_RX_WS2 `ISDP_WS_16
`define ISDP_RX_WS3 `ISDP_WS_16
`define ISDP_TX_WS0 `ISDP_WS_16
`define ISDP_TX_WS1 `ISDP_WS_16
`define ISDP_TX_WS2 `ISDP_WS_16
`define ISDP_TX_WS3 `ISDP_WS_16
`define ISDP_TX_CHAN_CODE 2'h3
`define ISDP_RX_CHAN_CODE 2'h3
`define ISDP_RX_PRESENT 1'h1
`define ISDP_TX_PRESENT 1'h1
`define ISDP_MASTER_CAP 1'h1
`define ISDP_DEPTH_2 2'h0
`define ISDP_DEPTH_4 2'h1
`define ISDP_DEPTH_8 2'h2
`define ISDP_DEPTH_16 2'h3
`define ISDP_FIFO_DEPTH_CODE `ISDP_DEPTH_16
`define ISDP_BUS_8 2'h0
`define ISDP_BUS_16 2'h1
`define ISDP_BUS_32 2'h2
`define ISDP_BUS_WIDTH_CODE `ISDP_BUS_32

// version value, arbitrary
`define ISDP_VERSION_VALUE 32'h00010000

// channel data layout
`define ISDP_NCH 4
`define ISDP_CH_W 2
`define ISDP_SAMPLE_W 32
`define ISDP_HALF_W 16
`define ISDP_TX_BUF_W 34

// build field widths
`define ISDP_WS_W 3
`define ISDP_CODE_W 2

`endif

/* core/isdp_rotor.v */
// rotation pointer over the enabled channels, lowest first, with wrap
`timescale 1ns/1ps
`include "isdp_regs.vh"
module isdp_rotor (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire [`ISDP_NCH-1:0] chan_enable,
   input wire advance,
   input wire restart,
   // state
   output reg [`ISDP_CH_W-1:0] ptr_r
);
   reg [`ISDP_CH_W-1:0] first_en;
   reg [`ISDP_CH_W-1:0] next_en;
   reg [`ISDP_CH_W-1:0] ptr_nxt;
   integer i;

   // lowest enabled channel and next enabled above the pointer
   always @* begin
      first_en = {`ISDP_CH_W{1'b0}};
      next_en = {`ISDP_CH_W{1'b0}};
      for (i = `ISDP_NCH - 1; i >= 0; i = i - 1) begin
         if (chan_enable[i]) begin
            first_en = i[`ISDP_CH_W-1:0];
         end
      end
      next_en = first_en;
      for (i = `ISDP_NCH - 1; i >= 0; i = i - 1) begin
         if (chan_enable[i] && (i > ptr_r)) begin
            next_en = i[`ISDP_CH_W-1:0];
         end
      end
      if (restart) begin
         ptr_nxt = first_en;
      end else if (advance || !chan_enable[ptr_r]) begin
         // a pointer left on a disabled channel moves on
         ptr_nxt = next_en;
      end else begin
         ptr_nxt = ptr_r;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r <= {`ISDP_CH_W{1'b0}};
      end else begin
         ptr_r <= ptr_nxt;
      end
   end
endmodule // isdp_rotor

/* core/isdp_top.v */
// shared receive and transmit dma ports with build parameter registers
`timescale 1ns/1ps
`include "isdp_regs.vh"
module isdp_top (
   // clock and reset
   input wire CLK,
   input wire RESET_N,
   // register bus
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [`ISDP_ADDR_W-1:0] PADDR,
   input wire [`ISDP_SAMPLE_W-1:0] PWDATA,
   output reg [`ISDP_SAMPLE_W-1:0] PRDATA,
   output reg PREADY,
   // receive channels
   input wire [`ISDP_NCH-1:0] RX_CH_ENABLE,
   input wire [`ISDP_NCH-1:0] RX_AVAIL,
   input wire [`ISDP_NCH*`ISDP_SAMPLE_W-1:0] RX_LEFT_DATA,
   input wire [`ISDP_NCH*`ISDP_SAMPLE_W-1:0] RX_RIGHT_DATA,
   output reg [`ISDP_NCH-1:0] RX_TAKE,
   // transmit channels
   input wire [`ISDP_NCH-1:0] TX_CH_ENABLE,
   output wire TX_VALID,
   input wire TX_READY,
   output wire [`ISDP_CH_W-1:0] TX_CHAN,
   output wire [`ISDP_SAMPLE_W-1:0] TX_PAIR
);
   reg rst_meta_r;
   reg rst_sync_r;
   reg [`ISDP_SAMPLE_W-1:0] prdata_nxt;
   reg rx_restart_r;
   reg tx_restart_r;
   reg rx_adv;
   reg tx_push;
   reg done;
   wire access;
   wire wr_rx_restart;
   wire wr_tx_restart;
   wire tx_in_ready;
   wire [`ISDP_CH_W-1:0] rx_ptr;
   wire [`ISDP_CH_W-1:0] tx_ptr;
   wire [`ISDP_SAMPLE_W-1:0] param_one;
   wire [`ISDP_SAMPLE_W-1:0] rx_pair;
   wire [`ISDP_TX_BUF_W-1:0] tx_out;
   wire sel_rx_restart;
   wire sel_tx_restart;
   wire rx_ready_ch;
   wire tx_advance;
   wire [`ISDP_NCH-1:0] rx_hit;
   wire [`ISDP_NCH-1:0] rx_take_nxt;
   wire [`ISDP_NCH*`ISDP_SAMPLE_W-1:0] rx_pairs;
   wire [`ISDP_SAMPLE_W-1:0] rx_sizes;
   wire [`ISDP_TX_BUF_W-1:0] tx_in_data;
   wire [`ISDP_WS_W-1:0] rx_ch0_resolution;
   wire [`ISDP_WS_W-1:0] rx_ch1_resolution;
   wire [`ISDP_WS_W-1:0] rx_ch2_resolution;
   wire [`ISDP_WS_W-1:0] rx_ch3_resolution;
   wire [`ISDP_WS_W-1:0] tx_ch0_resolution;
   wire [`ISDP_WS_W-1:0] tx_ch1_resolution;
   wire [`ISDP_WS_W-1:0] tx_ch2_resolution;
   wire [`ISDP_WS_W-1:0] tx_ch3_resolution;
   wire [`ISDP_CODE_W-1:0] tx_count_code;
   wire [`ISDP_CODE_W-1:0] rx_count_code;
   wire receiver_present;
   wire transmitter_present;
   wire master_capable;
   wire [`ISDP_CODE_W-1:0] fifo_depth_code;
   wire [`ISDP_CODE_W-1:0] bus_width_code;
   genvar ch;

   // reset release through two flops
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // restart register selects
   assign sel_rx_restart = (PADDR == `ISDP_OFF_RX_RESTART);
   assign sel_tx_restart = (PADDR == `ISDP_OFF_TX_RESTART);

   // access phase not yet answered
   assign access = PSEL & PENABLE & ~PREADY;
   assign wr_rx_restart = access & PWRITE & sel_rx_restart &
      PWDATA[`ISDP_RESTART_BIT];
   assign wr_tx_restart = access & PWRITE & sel_tx_restart &
      PWDATA[`ISDP_RESTART_BIT];

   // build fields
   assign rx_ch0_resolution = `ISDP_RX_WS0;
   assign rx_ch1_resolution = `ISDP_RX_WS1;
   assign rx_ch2_resolution = `ISDP_RX_WS2;
   assign rx_ch3_resolution = `ISDP_RX_WS3;
   assign tx_ch0_resolution = `ISDP_TX_WS0;
   assign tx_ch1_resolution = `ISDP_TX_WS1;
   assign tx_ch2_resolution = `ISDP_TX_WS2;
   assign tx_ch3_resolution = `ISDP_TX_WS3;
   assign tx_count_code = `ISDP_TX_CHAN_CODE;
   assign rx_count_code = `ISDP_RX_CHAN_CODE;
   assign receiver_present = `ISDP_RX_PRESENT;
   assign transmitter_present = `ISDP_TX_PRESENT;
   assign master_capable = `ISDP_MASTER_CAP;
   assign fifo_depth_code = `ISDP_FIFO_DEPTH_CODE;
   assign bus_width_code = `ISDP_BUS_WIDTH_CODE;

   // receive word size word
   assign rx_sizes = {19'h0, rx_ch3_resolution, rx_ch2_resolution, 1'b0,
      rx_ch1_resolution, rx_ch0_resolution};

   // build parameter word
   assign param_one = {4'h0,
      tx_ch3_resolution, tx_ch2_resolution,
      tx_ch1_resolution, tx_ch0_resolution,
      5'h00,
      tx_count_code, rx_count_code,
      receiver_present, transmitter_present, master_capable,
      fifo_depth_code,
      bus_width_code};

   // per-channel pair packing, readiness and take decode
   generate
      for (ch = 0; ch < `ISDP_NCH; ch = ch + 1) begin : g_chan
         assign rx_pairs[ch*`ISDP_SAMPLE_W +: `ISDP_SAMPLE_W] = {
            RX_RIGHT_DATA[ch*`ISDP_SAMPLE_W +: `ISDP_HALF_W],
            RX_LEFT_DATA[ch*`ISDP_SAMPLE_W +: `ISDP_HALF_W]};
         assign rx_hit[ch] = (rx_ptr == ch) & RX_CH_ENABLE[ch] &
            RX_AVAIL[ch];
         assign rx_take_nxt[ch] = rx_adv & rx_hit[ch];
      end
   endgenerate

   // packed stereo pair of the pointed receive channel
   assign rx_ready_ch = |rx_hit;
   assign rx_pair = rx_pairs[rx_ptr*`ISDP_SAMPLE_W +: `ISDP_SAMPLE_W];

   // transmit pair entering the buffer with its channel
   assign tx_advance = tx_push & tx_in_ready;
   assign tx_in_data = {tx_ptr, PWDATA};

   // decode and read mux
   always @* begin
      prdata_nxt = {`ISDP_SAMPLE_W{1'b0}};
      rx_adv = 1'b0;
      tx_push = 1'b0;
      done = access;
      if (access) begin
         case (PADDR)
            `ISDP_OFF_RX_PORT: begin
               if (!PWRITE && rx_ready_ch) begin
                  prdata_nxt = rx_pair;
                  rx_adv = 1'b1;
               end
            end
            `ISDP_OFF_RX_RESTART: begin
               prdata_nxt = {31'h0, rx_restart_r};
            end
            `ISDP_OFF_TX_PORT: begin
               if (PWRITE) begin
                  tx_push = 1'b1;
                  done = tx_in_ready;
               end
            end
            `ISDP_OFF_TX_RESTART: begin
               prdata_nxt = {31'h0, tx_restart_r};
            end
            `ISDP_OFF_PARAM_ONE: begin
               prdata_nxt = param_one;
            end
            `ISDP_OFF_VERSION: begin
               prdata_nxt = `ISDP_VERSION_VALUE;
            end
            `ISDP_OFF_RX_SIZES: begin
               prdata_nxt = rx_sizes;
            end
            default: begin
               prdata_nxt = {`ISDP_SAMPLE_W{1'b0}};
            end
         endcase
      end
   end

   // bus answer, pop pulses, self-clearing restart bits
   always @(posedge CLK or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         PRDATA <= {`ISDP_SAMPLE_W{1'b0}};
         PREADY <= 1'b0;
         RX_TAKE <= {`ISDP_NCH{1'b0}};
         rx_restart_r <= 1'b0;
         tx_restart_r <= 1'b0;
      end else begin
         PREADY <= done;
         if (done) begin
            PRDATA <= prdata_nxt;
         end
         RX_TAKE <= rx_take_nxt;
         rx_restart_r <= wr_rx_restart;
         tx_restart_r <= wr_tx_restart;
      end
   end

   // receive rotation
   isdp_rotor u_rx_rotor (
      .clk(CLK),
      .rst_n(rst_sync_r),
      .chan_enable(RX_CH_ENABLE),
      .advance(rx_adv),
      .restart(wr_rx_restart),
      .ptr_r(rx_ptr)
   );

   // transmit rotation, stepped as each pair enters the buffer
   isdp_rotor u_tx_rotor (
      .clk(CLK),
      .rst_n(rst_sync_r),
      .chan_enable(TX_CH_ENABLE),
      .advance(tx_advance),
      .restart(wr_tx_restart),
      .ptr_r(tx_ptr)
   );

   // transmit pairs with their target channel
   isdp_buf2 u_tx_buf (
      .clk(CLK),
      .rst_n(rst_sync_r),
      .in_valid(tx_push),
      .in_ready_r(tx_in_ready),
      .in_data(tx_in_data),
      .out_valid_r(TX_VALID),
      .out_ready(TX_READY),
      .out_data_r(tx_out)
   );

   assign TX_CHAN = tx_out[`ISDP_TX_BUF_W-1:`ISDP_SAMPLE_W];
   assign TX_PAIR = tx_out[`ISDP_SAMPLE_W-1:0];
endmodule // isdp_top

/* test/isdp_sink.sv */
// transmit sink with stall and slow answer modes
`timescale 1ns/1ps
module isdp_sink (
   // clock
   input wire clk,
   // modes
   input wire stall,
   input wire slow,
   // stream
   output reg ready
);
   initial ready = 1'b0;
   // slow mode accepts every other cycle
   always @(posedge clk) begin
      ready <= !stall && !(slow && ready);
   end
endmodule // isdp_sink

/* test/isdp_top_asserts.sv */
// concurrent checks on the dma port block pins
`timescale 1ns/1ps
module isdp_chk (
   // clock and reset
   input wire CLK,
   input wire RESET_N,
   // register bus
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PRDATA,
   input wire PREADY,
   // channels
   input wire [3:0] RX_CH_ENABLE,
   input wire [3:0] RX_TAKE,
   input wire [3:0] TX_CH_ENABLE,
   input wire TX_VALID,
   input wire TX_READY,
   input wire [1:0] TX_CHAN,
   input wire [31:0] TX_PAIR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire rd = PREADY && !PWRITE;
   property p_take_onehot;
      $onehot0(RX_TAKE);
   endproperty
   a_take_onehot: assert property (p_take_onehot)
      else $error("take not one-hot");
   property p_take_read;
      |RX_TAKE |-> rd && PADDR == 12'h1c0;
   endproperty
   a_take_read: assert property (p_take_read)
      else $error("take without port read");
   property p_take_en;
      |RX_TAKE |-> |(RX_TAKE & RX_CH_ENABLE);
   endproperty
   a_take_en: assert property (p_take_en)
      else $error("take on disabled channel");
   property p_tx_hold;
      TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_PAIR) && $stable(TX_CHAN);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("pair dropped while stalled");
   property p_tx_en;
      TX_VALID |-> TX_CH_ENABLE[TX_CHAN];
   endproperty
   a_tx_en: assert property (p_tx_en)
      else $error("pair aimed at disabled channel");
   property p_param;
      rd && PADDR == 12'h1f4 |-> PRDATA == 32'h024907fe;
   endproperty
   a_param: assert property (p_param)
      else $error("parameter word wrong");
   property p_sizes;
      rd && PADDR == 12'h1f0 |-> PRDATA == 32'h00000489;
   endproperty
   a_sizes: assert property (p_sizes)
      else $error("receive size word wrong");
   property p_restart_rd;
      rd && (PADDR == 12'h1c4 || PADDR == 12'h1cc) |-> PRDATA == 32'h0;
   endproperty
   a_restart_rd: assert property (p_restart_rd)
      else $error("restart register not zero");
   c_rx: cover property (rd && PADDR == 12'h1c0);
   c_stall: cover property (TX_VALID && !TX_READY);
   c_restart: cover property (PREADY && PWRITE && PADDR == 12'h1cc);
endmodule // isdp_chk
bind isdp_top isdp_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .RX_CH_ENABLE(RX_CH_ENABLE), .RX_TAKE(RX_TAKE), .TX_CH_ENABLE(TX_CH_ENABLE),
   .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_CHAN(TX_CHAN),
   .TX_PAIR(TX_PAIR));

/* test/test_isdp_top.sv */
// self-checking bench for the dma port block
`timescale 1ns/1ps
`include "isdp_regs.vh"
module test_isdp_top;
   typedef struct {logic [11:0] a; logic [31:0] e;} isdp_row_t;
   logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic PREADY, TX_VALID, TX_READY, stall = 1, slow = 1;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, PRDATA, q, TX_PAIR;
   logic [3:0] RX_CH_ENABLE = 4'ha, RX_AVAIL = 4'hf, RX_TAKE;
   logic [3:0] TX_CH_ENABLE = 4'h6;
   logic [1:0] TX_CHAN;
   logic [127:0] lft = 128'hffff1003_ffff1002_ffff1001_ffff1000;
   logic [127:0] rgt = 128'heeee2003_eeee2002_eeee2001_eeee2000;
   logic [33:0] got[$];
   logic [33:0] txs[4] = '{34'h1000000a0, 34'h2000000a1, 34'h1000000a2,
      34'h1000000a3};
   int rxs[4] = '{1, 3, 1, 1};
   int failures = 0, check_count = 0, t0;
   isdp_row_t rows[6] = '{'{12'h1f4, 32'h024907fe}, '{12'h1f0, 32'h489},
      '{12'h1c4, 32'h0}, '{12'h1cc, 32'h0},
      '{`ISDP_OFF_VERSION, `ISDP_VERSION_VALUE}, '{12'h100, 32'h0}};
   isdp_top uut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .RX_CH_ENABLE(RX_CH_ENABLE),
      .RX_AVAIL(RX_AVAIL), .RX_LEFT_DATA(lft), .RX_RIGHT_DATA(rgt),
      .RX_TAKE(RX_TAKE), .TX_CH_ENABLE(TX_CH_ENABLE), .TX_VALID(TX_VALID),
      .TX_READY(TX_READY), .TX_CHAN(TX_CHAN), .TX_PAIR(TX_PAIR));
   isdp_sink u_sink (.clk(CLK), .stall(stall), .slow(slow), .ready(TX_READY));
   initial forever #20 CLK = ~CLK;
   // record every pair the sink accepts
   always @(negedge CLK) if (TX_VALID === 1'b1 && TX_READY === 1'b1)
      got.push_back({TX_CHAN, TX_PAIR});
   task automatic chk(input string nm, input logic [33:0] e,
      input logic [33:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge CLK);
      #1 PSEL = 1;
      PWRITE = w;
      PADDR = a;
      PWDATA = d;
      @(posedge CLK);
      #1 PENABLE = 1;
      do begin
         @(posedge CLK);
         #1 n++;
      end while (PREADY !== 1'b1 && n < 50);
      chk("bus answer", 1, n < 50);
      r = PRDATA;
      @(posedge CLK);
      #1 PSEL = 0;
      PENABLE = 0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000 failures++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge CLK);
      #1 RESET_N = 1;
      repeat (3) @(posedge CLK);
      foreach (rows[i]) begin
         bus(1, rows[i].a, 32'hffffffff, q);
         bus(0, rows[i].a, 32'h0, q);
         chk("reg word", rows[i].e, q);
      end
      foreach (rxs[i]) begin
         if (i == 3) bus(1, `ISDP_OFF_RX_RESTART, 32'h1, q);
         bus(0, `ISDP_OFF_RX_PORT, 32'h0, q);
         chk("rx pair", 32'h20001000 + 32'h10001 * rxs[i], q);
      end
      RX_AVAIL = 4'h7;
      bus(0, `ISDP_OFF_RX_PORT, 32'h0, q);
      chk("rx empty", 32'h0, q);
      RX_AVAIL = 4'hf;
      bus(0, `ISDP_OFF_RX_PORT, 32'h0, q);
      chk("rx held", 32'h20031003, q);
      bus(1, `ISDP_OFF_TX_PORT, 32'ha0, q);
      bus(1, `ISDP_OFF_TX_PORT, 32'ha1, q);
      t0 = $time;
      fork
         bus(1, `ISDP_OFF_TX_PORT, 32'ha2, q);
         #400 stall = 0;
      join
      chk("tx full wait", 1, $time - t0 > 400);
      bus(1, `ISDP_OFF_TX_RESTART, 32'h1, q);
      bus(1, `ISDP_OFF_TX_PORT, 32'ha3, q);
      repeat (20) @(posedge CLK);
      chk("tx count", 4, got.size());
      foreach (txs[i]) chk("tx pair", txs[i], got[i]);
      #1 RESET_N = 0;
      @(posedge CLK);
      #1 chk("reset outs", 0, {PREADY, TX_VALID, RX_TAKE});
      @(posedge CLK);
      #1 RESET_N = 1;
      repeat (3) @(posedge CLK);
      bus(0, `ISDP_OFF_RX_PORT, 32'h0, q);
      chk("rx first", 32'h20011001, q);
      wrap_up;
   end
endmodule // test_isdp_top
